// [include/wdsr_map.svh]
`ifndef WDSR_MAP_SVH
`define WDSR_MAP_SVH

// ****************************************************************
// Register indices; byte address is four times the index
// ****************************************************************
`define WDSR_IDX_SERVICE 10'h0A6
`define WDSR_IDX_PERIOD 10'h0A7
`define WDSR_IDX_STATUS 10'h0A8

// ****************************************************************
// Field layout and reset values
// ****************************************************************
`define WDSR_SEL_MSB 2
`define WDSR_SEL_LSB 0
`define WDSR_PERIOD_RST 3'h0
`define WDSR_ARM_BYTE1 8'h1E
`define WDSR_ARM_BYTE2 8'hE1

// ****************************************************************
// Counter structure and timing
// ****************************************************************
`define WDSR_FIXED_BITS 14
`define WDSR_PROG_BITS 7
`define WDSR_OSC_PER_MC 3'h6
`define WDSR_PULSE_OSC 7'h60
`define WDSR_MIN_RST_MC 4'h2
`define WDSR_MIN_RST_CYC (`WDSR_MIN_RST_MC * `WDSR_OSC_PER_MC)
`define WDSR_CLK_PS 32'h1388
`define WDSR_GLITCH_PS 32'hC350
`define WDSR_GLITCH_CYC \
    ((`WDSR_GLITCH_PS + `WDSR_CLK_PS - 32'h1) / `WDSR_CLK_PS)
`define WDSR_NO_FILTER_CYC 32'h1

`endif

// [include/wdsr_pkg.sv]
`default_nettype none

package wdsr_pkg;

    // ************************************************************
    // Arming sequence detector states
    // ************************************************************
    typedef enum logic {
        WDSR_SEQ_IDLE,
        WDSR_SEQ_GOT_FIRST
    } wdsr_seq_t;

    // ************************************************************
    // Status register layout
    // ************************************************************
    typedef struct packed {
        logic [28:0] unused;
        logic supply_low;
        logic wd_fired;
        logic armed;
    } wdsr_status_t;

endpackage

`default_nettype wire

// [rtl/wdsr_glitch_filter.sv]
`include "wdsr_map.svh"

`default_nettype none

module wdsr_glitch_filter #(
    parameter int unsigned HOLD_CYC = 1
) (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic raw_i,
    output logic level_o
);

    // ************************************************************
    // Three-stage synchroniser
    // ************************************************************
    logic s1_ff, s2_ff, s3_ff;
    logic out_ff;
    logic [3:0] cnt_ff;
    logic [3:0] nxt_cnt;
    logic nxt_out;

    // Stable once stages two and three agree
    wire agree = s2_ff == s3_ff;
    wire differ = agree && (s3_ff != out_ff);
    wire held = cnt_ff == 4'(HOLD_CYC - 1);

    // Output flips only after HOLD_CYC stable differing cycles
    assign nxt_out = (differ && held) ? s3_ff : out_ff;
    assign nxt_cnt = (differ && !held) ? cnt_ff + 4'h1 : 4'h0;
    assign level_o = out_ff;

    // Sync and filter registers
    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s1_ff <= 1'b0;
            s2_ff <= 1'b0;
            s3_ff <= 1'b0;
            out_ff <= 1'b0;
            cnt_ff <= 4'h0;
        end else begin
            s1_ff <= raw_i;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            out_ff <= nxt_out;
            cnt_ff <= nxt_cnt;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    filter_hold_a: assert property ( // [RULE12]
        @(posedge clk_i) disable iff (!reset_n_i)
        (out_ff != $past(out_ff)) |-> $past(cnt_ff) == 4'(HOLD_CYC - 1))
        else $error("filtered level changed before hold time");

endmodule

`default_nettype wire

// [rtl/wdsr_top.sv]
// Notes on behaviour
// [RULE1] Timer comes up disarmed after any reset
// [RULE2] Arming needs write 1EH then E1H
// [RULE3] Armed timer advances once per machine cycle
// [RULE4] Only reset or overflow disarms the timer
// [RULE5] Overflow drives a 96-clock reset pin pulse
// [RULE6] Fixed 14-bit counter plus 7-bit extension
// [RULE7] 3-bit period field, resets zero, rest reserved
// [RULE8] Timeout is 2^(14+S)-1 machine cycles
// [RULE9] Service register write-only; sequence restarts count
// [RULE10] Software services timer within the period
// [RULE11] Supply drop holds chip in reset
// [RULE12] Supply glitches under 50 ns are ignored
// [RULE13] Reset pin actively driven low by monitors
// [RULE14] Four sources assert the internal reset
// [RULE15] Internal reset lasts two machine cycles minimum
// [RULE16] Wrong service byte restarts sequence detection
//
// Design decision made here: register access over APB.

`include "wdsr_map.svh"

`default_nettype none

module wdsr_top
    import wdsr_pkg::*;
(
    input wire logic CLK_I,
    input wire logic RESET_N_I,
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [11:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    input wire logic RST_PIN_I,
    output logic RST_PIN_O,
    output logic RST_PIN_OE_O,
    input wire logic PWR_UP_BUSY_I,
    input wire logic SUPPLY_LOW_I,
    output logic SYS_RESET_N_O
);

    // ************************************************************
    // Declarations
    // ************************************************************
    logic pin_low, pup_busy, supply_drop;
    logic pready_ff, pslverr_ff;
    logic [31:0] prdata_ff;
    logic int_rst_ff, nxt_int_rst;
    logic [3:0] hold_ff, nxt_hold;
    logic [2:0] pre_ff, nxt_pre;
    logic [`WDSR_FIXED_BITS-1:0] low_ff, nxt_low;
    logic [`WDSR_PROG_BITS-1:0] high_ff, nxt_high;
    logic armed_ff, nxt_armed;
    logic [2:0] sel_ff, nxt_sel;
    wdsr_seq_t seq_ff, nxt_seq;
    logic pulse_ff, nxt_pulse;
    logic [6:0] pulse_cnt_ff, nxt_pulse_cnt;
    logic wd_fired_ff;
    logic pin_drive_ff;
    logic [7:0] rst_len_ff;
    wdsr_status_t status;

    // ************************************************************
    // Input conditioning
    // ************************************************************
    wdsr_glitch_filter #(
        .HOLD_CYC(`WDSR_NO_FILTER_CYC)
    ) u_pin_filter (
        .clk_i(CLK_I),
        .reset_n_i(RESET_N_I),
        .raw_i(~RST_PIN_I),
        .level_o(pin_low)
    );

    wdsr_glitch_filter #(
        .HOLD_CYC(`WDSR_NO_FILTER_CYC)
    ) u_pup_filter (
        .clk_i(CLK_I),
        .reset_n_i(RESET_N_I),
        .raw_i(PWR_UP_BUSY_I),
        .level_o(pup_busy)
    );

    // Supply drop must persist past the glitch window
    wdsr_glitch_filter #(
        .HOLD_CYC(`WDSR_GLITCH_CYC) // RULE12
    ) u_supply_filter (
        .clk_i(CLK_I),
        .reset_n_i(RESET_N_I),
        .raw_i(SUPPLY_LOW_I),
        .level_o(supply_drop)
    );

    // ************************************************************
    // APB decode
    // ************************************************************
    wire apb_acc = PSEL_I && PENABLE_I;
    wire apb_first = apb_acc && !pready_ff;
    wire apb_done = apb_acc && pready_ff;
    wire [9:0] reg_idx = PADDR_I[11:2];
    wire aligned = PADDR_I[1:0] == 2'h0;
    wire hit_svc = aligned && (reg_idx == `WDSR_IDX_SERVICE);
    wire hit_per = aligned && (reg_idx == `WDSR_IDX_PERIOD);
    wire hit_sts = aligned && (reg_idx == `WDSR_IDX_STATUS);
    wire unmapped = !(hit_svc || hit_per || hit_sts);
    wire svc_wr = apb_done && PWRITE_I && hit_svc;
    wire per_wr = apb_done && PWRITE_I && hit_per;
    wire [7:0] svc_byte = PWDATA_I[7:0];

    // Read mux; service register reads zero
    assign status = '{unused: 29'h0,
                      supply_low: supply_drop,
                      wd_fired: wd_fired_ff,
                      armed: armed_ff};
    wire [31:0] rd_per = {29'h0, sel_ff};
    wire [31:0] rd_mux = hit_per ? rd_per : // RULE7
                         hit_sts ? status : 32'h0; // RULE9

    // Bus answer registers, one wait state
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0;
        end else begin
            pready_ff <= apb_first;
            pslverr_ff <= apb_first && unmapped;
            prdata_ff <= apb_first ? rd_mux : prdata_ff;
        end
    end

    assign PREADY_O = pready_ff;
    assign PSLVERR_O = pslverr_ff;
    assign PRDATA_O = prdata_ff;

    // ************************************************************
    // Arming sequence detector
    // ************************************************************
    wire seq_first = seq_ff == WDSR_SEQ_GOT_FIRST;
    wire got_byte1 = svc_byte == `WDSR_ARM_BYTE1;
    wire arm_cmd = svc_wr && seq_first &&
                   (svc_byte == `WDSR_ARM_BYTE2); // RULE2 RULE9
    assign nxt_seq = int_rst_ff ? WDSR_SEQ_IDLE :
                     !svc_wr ? seq_ff :
                     (!seq_first && got_byte1) ? WDSR_SEQ_GOT_FIRST :
                     WDSR_SEQ_IDLE; // RULE16

    // ************************************************************
    // Period select register
    // ************************************************************
    assign nxt_sel = int_rst_ff ? `WDSR_PERIOD_RST :
                     per_wr ? PWDATA_I[`WDSR_SEL_MSB:`WDSR_SEL_LSB] :
                     sel_ff; // RULE7

    // ************************************************************
    // Machine cycle prescaler and counter chain
    // ************************************************************
    wire mc_tick = armed_ff &&
                   (pre_ff == `WDSR_OSC_PER_MC - 3'h1); // RULE3
    wire [7:0] sel_span = 8'h01 << sel_ff;
    wire [`WDSR_PROG_BITS-1:0] prog_mask =
        `WDSR_PROG_BITS'(sel_span - 8'h01);
    wire low_full = &low_ff;
    wire term_hit = low_full &&
                    ((high_ff & prog_mask) == prog_mask); // RULE6 RULE8
    wire wd_fire = armed_ff && term_hit && (pre_ff == 3'h0);
    wire clr_cnt = int_rst_ff || arm_cmd || !armed_ff || wd_fire;

    assign nxt_pre = (clr_cnt || mc_tick) ? 3'h0 : pre_ff + 3'h1;
    assign nxt_low = clr_cnt ? '0 :
                     mc_tick ? low_ff + 1'b1 : low_ff; // RULE3
    assign nxt_high = clr_cnt ? '0 :
                      (mc_tick && low_full) ? high_ff + 1'b1 :
                      high_ff; // RULE6

    // Only reset or overflow clears the armed state
    assign nxt_armed = (int_rst_ff || wd_fire) ? 1'b0 : // RULE1 RULE4
                       arm_cmd ? 1'b1 : armed_ff;

    // Watchdog registers
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            seq_ff <= WDSR_SEQ_IDLE;
            sel_ff <= `WDSR_PERIOD_RST;
            pre_ff <= 3'h0;
            low_ff <= '0;
            high_ff <= '0;
            armed_ff <= 1'b0;
        end else begin
            seq_ff <= nxt_seq;
            sel_ff <= nxt_sel;
            pre_ff <= nxt_pre;
            low_ff <= nxt_low;
            high_ff <= nxt_high;
            armed_ff <= nxt_armed;
        end
    end

    // ************************************************************
    // Overflow reset pulse
    // ************************************************************
    wire pulse_end = pulse_cnt_ff == `WDSR_PULSE_OSC - 7'h1;
    assign nxt_pulse = wd_fire ? 1'b1 :
                       (pulse_ff && pulse_end) ? 1'b0 : pulse_ff; // RULE5
    assign nxt_pulse_cnt = (wd_fire || !pulse_ff) ? 7'h0 :
                           pulse_cnt_ff + 7'h1;

    // Pulse registers and sticky overflow flag
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            pulse_ff <= 1'b0;
            pulse_cnt_ff <= 7'h0;
            wd_fired_ff <= 1'b0;
        end else begin
            pulse_ff <= nxt_pulse;
            pulse_cnt_ff <= nxt_pulse_cnt;
            wd_fired_ff <= wd_fired_ff || wd_fire;
        end
    end

    // ************************************************************
    // Internal reset combiner and stretcher
    // ************************************************************
    wire any_src = pin_low || pup_busy ||
                   supply_drop || pulse_ff; // RULE11 RULE14
    wire drive_pin = pulse_ff || pup_busy || supply_drop;
    assign nxt_int_rst = any_src || (hold_ff != 4'h0);
    assign nxt_hold = any_src ? 4'(`WDSR_MIN_RST_CYC) : // RULE15
                      (hold_ff != 4'h0) ? hold_ff - 4'h1 : 4'h0;

    // Reset hold and pin drive registers
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            int_rst_ff <= 1'b1;
            hold_ff <= 4'(`WDSR_MIN_RST_CYC); // RULE15
            pin_drive_ff <= 1'b0;
        end else begin
            int_rst_ff <= nxt_int_rst;
            hold_ff <= nxt_hold;
            pin_drive_ff <= drive_pin; // RULE13
        end
    end

    assign SYS_RESET_N_O = !int_rst_ff;
    assign RST_PIN_O = 1'b0; // RULE13
    assign RST_PIN_OE_O = pin_drive_ff;

    // ************************************************************
    // Check helpers
    // ************************************************************
    always_ff @(posedge CLK_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            rst_len_ff <= 8'h0;
        end else begin
            rst_len_ff <= !int_rst_ff ? 8'h0 :
                          (rst_len_ff == 8'hFF) ? rst_len_ff :
                          rst_len_ff + 8'h1;
        end
    end

    wire [21:0] term_val = (22'h1 << (`WDSR_FIXED_BITS + sel_ff)) - 22'h1;
    wire [20:0] cnt_now = {high_ff, low_ff};

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (!RESET_N_I);

    disarm_on_reset_a: assert property ( // [RULE1]
        int_rst_ff |=> !armed_ff)
        else $error("timer armed during internal reset");

    arm_sequence_a: assert property ( // [RULE2]
        $rose(armed_ff) |-> $past(svc_wr && seq_first &&
            svc_byte == `WDSR_ARM_BYTE2))
        else $error("timer armed without full sequence");

    count_step_a: assert property ( // [RULE3]
        armed_ff && mc_tick && !clr_cnt |=> low_ff == $past(low_ff) + 1'b1)
        else $error("counter did not advance on machine cycle");

    tick_spacing_a: assert property ( // [RULE3]
        mc_tick && !clr_cnt |=> !mc_tick [*5])
        else $error("machine cycle shorter than six clocks");

    stay_armed_a: assert property ( // [RULE4]
        armed_ff && !int_rst_ff && !wd_fire |=> armed_ff)
        else $error("timer disarmed without reset");

    pulse_length_a: assert property ( // [RULE5]
        $fell(pulse_ff) |-> $past(pulse_cnt_ff) == `WDSR_PULSE_OSC - 7'h1)
        else $error("reset pulse length wrong");

    fire_pulse_a: assert property ( // [RULE5]
        wd_fire |=> pulse_ff ##1 RST_PIN_OE_O && !RST_PIN_O)
        else $error("overflow did not drive reset pin");

    overflow_value_a: assert property ( // [RULE8]
        wd_fire |-> {1'b0, cnt_now} == term_val)
        else $error("overflow at wrong count");

    period_read_a: assert property ( // [RULE7]
        apb_first && hit_per && !PWRITE_I |=> PRDATA_O[31:3] == 29'h0)
        else $error("reserved period bits not zero");

    service_read_a: assert property ( // [RULE9]
        apb_first && hit_svc |=> PRDATA_O == 32'h0)
        else $error("service register readable");

    service_restart_a: assert property ( // [RULE9]
        arm_cmd && armed_ff && !int_rst_ff |=> cnt_now == 21'h0 && armed_ff)
        else $error("service sequence did not restart count");

    supply_hold_a: assert property ( // [RULE11]
        supply_drop |=> int_rst_ff)
        else $error("supply drop not holding reset");

    pin_drive_a: assert property ( // [RULE13]
        (pup_busy || supply_drop) |=> RST_PIN_OE_O)
        else $error("reset pin not driven by monitor");

    source_reset_a: assert property ( // [RULE14]
        pin_low |=> !SYS_RESET_N_O)
        else $error("pin source did not assert reset");

    min_reset_a: assert property ( // [RULE15]
        $fell(int_rst_ff) |-> $past(rst_len_ff) >= 8'(`WDSR_MIN_RST_CYC))
        else $error("internal reset too short");

    seq_abort_a: assert property ( // [RULE16]
        svc_wr && seq_first && svc_byte != `WDSR_ARM_BYTE2 |=>
            seq_ff == WDSR_SEQ_IDLE)
        else $error("bad byte did not abort sequence");

    arm_cover_c: cover property ($rose(armed_ff));
    fire_cover_c: cover property (wd_fire);
    restart_cover_c: cover property (arm_cmd && armed_ff);
    supply_cover_c: cover property ($rose(supply_drop));

endmodule

`default_nettype wire

// [test/wdsr_top_test.sv]
`include "wdsr_map.svh"

`default_nettype none

module wdsr_top_test
    import wdsr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    // ************************************************************
    // Bench signals and register addresses
    // ************************************************************
    localparam logic [11:0] A_SRV = {`WDSR_IDX_SERVICE, 2'b00};
    localparam logic [11:0] A_PRD = {`WDSR_IDX_PERIOD, 2'b00};
    localparam logic [11:0] A_STS = {`WDSR_IDX_STATUS, 2'b00};
    localparam logic [11:0] A_BAD = 12'h2A4;
    // Broken arming bytes, first byte in the top bits
    localparam logic [47:0] BAD_SEQ = 48'h1E1E_E11E_55E1;
    localparam int TMO = ((1 << `WDSR_FIXED_BITS) - 1) * `WDSR_OSC_PER_MC;

    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic pin_o;
    logic pin_oe;
    logic sys_n;
    logic ext_low = 1'b0;
    logic pwr_up = 1'b0;
    logic sup_low = 1'b0;
    wire logic pin_lvl;
    int bad_count = 0;
    int checked = 0;

    // Pin has a pull-up; low when the device or outside drives it
    assign pin_lvl = !((pin_oe && !pin_o) || ext_low);

    // Clock of 5 ns period
    always #2.5 clk = ~clk;

    wdsr_top DUT (
        .CLK_I(clk),
        .RESET_N_I(rst_n),
        .PSEL_I(psel),
        .PENABLE_I(pen),
        .PWRITE_I(pwr),
        .PADDR_I(paddr),
        .PWDATA_I(pwdata),
        .PRDATA_O(prdata),
        .PREADY_O(pready),
        .PSLVERR_O(pslverr),
        .RST_PIN_I(pin_lvl),
        .RST_PIN_O(pin_o),
        .RST_PIN_OE_O(pin_oe),
        .PWR_UP_BUSY_I(pwr_up),
        .SUPPLY_LOW_I(sup_low),
        .SYS_RESET_N_O(sys_n)
    );

    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic summarize();
        if (bad_count == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Compare one value
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        checked++;
        if (g !== e) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask

    // One APB transfer, waits for the slave answer
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] wd, output logic [31:0] rd,
                       output logic err);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        pen <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
        chk("apb answer", 1, pready);
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask

    task automatic rd(input logic [11:0] a, output logic [31:0] d);
        logic e;
        apb(1'b0, a, 32'h0000_0000, d, e);
    endtask

    // Wait for the internal reset to release
    task automatic wait_up();
        int n;
        n = 0;
        while (sys_n !== 1'b1 && n < 1000) begin
            @(posedge clk);
            n++;
        end
        chk("reset release", 1, sys_n);
    endtask

    // ************************************************************
    // Test sequence
    // ************************************************************
    initial begin
        logic [31:0] d;
        logic e;
        logic ok;
        int n;
        wdsr_status_t st;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        wait_up();
        rd(A_STS, d);
        chk("status idle", 32'h0, d);
        rd(A_PRD, d);
        chk("period reset", 32'h0, d);
        wr(A_PRD, 32'h0000_00FF);
        rd(A_PRD, d);
        chk("period field", 32'h7, d);
        apb(1'b0, A_SRV, 32'h0, d, e);
        chk("service read", 32'h0, d);
        apb(1'b1, A_BAD, 32'h1E, d, e);
        chk("unmapped err", 1, e);
        // Broken arming sequences must not arm
        for (int i = 0; i < 6; i++) begin
            wr(A_SRV, {24'h0, BAD_SEQ[47 - 8 * i -: 8]});
        end
        rd(A_STS, d);
        chk("not armed", 32'h0, d);
        wr(A_PRD, 32'h5);
        wr(A_SRV, {24'h0, `WDSR_ARM_BYTE1});
        wr(A_SRV, {24'h0, `WDSR_ARM_BYTE2});
        st = '0;
        st.armed = 1'b1;
        rd(A_STS, d);
        chk("armed", st, d);
        wr(A_SRV, 32'h0);
        wr(A_PRD, 32'h3);
        rd(A_STS, d);
        chk("still armed", st, d);
        // Supply drop holds reset and drives the pin
        sup_low <= 1'b1;
        repeat (40) @(posedge clk);
        chk("supply reset", 0, sys_n);
        chk("supply pin", 1, pin_oe);
        st = '0;
        st.supply_low = 1'b1;
        rd(A_STS, d);
        chk("supply status", st, d);
        sup_low <= 1'b0;
        wait_up();
        rd(A_STS, d);
        chk("disarmed", 32'h0, d);
        rd(A_PRD, d);
        chk("period reset again", 32'h0, d);
        // Short supply glitch is filtered
        sup_low <= 1'b1;
        repeat (9) @(posedge clk);
        sup_low <= 1'b0;
        ok = 1'b1;
        repeat (30) begin
            @(posedge clk);
            if (sys_n !== 1'b1) ok = 1'b0;
        end
        chk("glitch ignored", 1, ok);
        // Two-cycle pin pulse gives a full-length reset
        ext_low <= 1'b1;
        repeat (2) @(posedge clk);
        ext_low <= 1'b0;
        n = 0;
        while (sys_n === 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        chk("pin reset", 0, sys_n);
        n = 0;
        while (sys_n !== 1'b1 && n < 1000) begin
            @(posedge clk);
            n++;
        end
        chk("reset length", 1, n >= `WDSR_MIN_RST_CYC);
        // Power-up monitor busy
        pwr_up <= 1'b1;
        repeat (20) @(posedge clk);
        chk("powerup reset", 0, sys_n);
        chk("powerup pin", 1, pin_oe);
        pwr_up <= 1'b0;
        wait_up();
        // Arm, service part way, then let it overflow
        wr(A_SRV, {24'h0, `WDSR_ARM_BYTE1});
        wr(A_SRV, {24'h0, `WDSR_ARM_BYTE2});
        repeat (600) @(posedge clk);
        wr(A_SRV, {24'h0, `WDSR_ARM_BYTE1});
        wr(A_SRV, {24'h0, `WDSR_ARM_BYTE2});
        n = 0;
        while (pin_oe !== 1'b1 && n < 100000) begin
            @(posedge clk);
            n++;
        end
        chk("timeout", 1, n >= TMO - 4 && n <= TMO + 6);
        chk("pin drive", 0, pin_o);
        chk("wd reset", 0, sys_n);
        n = 0;
        while (pin_oe === 1'b1 && n < 200) begin
            @(posedge clk);
            n++;
        end
        chk("pulse length", `WDSR_PULSE_OSC, n);
        wait_up();
        st = '0;
        st.wd_fired = 1'b1;
        rd(A_STS, d);
        chk("after overflow", st, d);
        rd(A_PRD, d);
        chk("period cleared", 32'h0, d);
        summarize();
    end

    // Hang guard
    initial begin
        repeat (120000) @(posedge clk);
        bad_count++;
        summarize();
    end

endmodule

`default_nettype wire
